// *** include/usp_params.svh ***
// constants of the ultrasonic serial response port
`ifndef USP_PARAMS_SVH
`define USP_PARAMS_SVH

// wishbone register byte offsets
`define USP_OFS_CTRL        8'h00
`define USP_OFS_STATUS      8'h04
`define USP_OFS_LASTDIAG    8'h08

// control register fields
`define USP_CTRL_DIAGSEL    0
`define USP_CTRL_ADDR_LO    1
`define USP_CTRL_IOSEL      4
`define USP_CTRL_RST        5'h00

// status register fields
`define USP_ST_ERR_HI       5
`define USP_ST_SYNCACT      6
`define USP_ST_RESPACT      7
`define USP_ST_IOXCVR       8

// protocol codes
`define USP_SYNC_BYTE       8'h55
`define USP_CMD_REGREAD     5'h09
`define USP_CMD_LAST        5'h19
`define USP_CMD_BCAST_LO    5'h11
`define USP_DIAG_TOP        2'h1

// timing
`define USP_CLK_MHZ         50
`define USP_MIN_BIT_NS      125
`define USP_MAX_BIT_NS      2000
`define USP_MIN_BIT_CYC     ((`USP_MIN_BIT_NS * `USP_CLK_MHZ + 999) / 1000)
`define USP_MAX_BIT_CYC     ((`USP_MAX_BIT_NS * `USP_CLK_MHZ) / 1000)
`define USP_WIDTH_TOL       2
`define USP_IDLE_CYC        256

`endif

// *** include/usp_pkg.sv ***
// types of the ultrasonic serial response port
package usp_pkg;
   typedef enum logic [6:0] {
      ST_SYNC = 7'b0000001,
      ST_CMD  = 7'b0000010,
      ST_DATA = 7'b0000100,
      ST_CSUM = 7'b0001000,
      ST_GAP  = 7'b0010000,
      ST_TX   = 7'b0100000,
      ST_IGN  = 7'b1000000
   } usp_state_t;
endpackage

// *** hdl/usp_port.sv ***
// synchronous-mode serial response port with diagnostic byte and wishbone control
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "usp_params.svh"
// Functional notes
// - device waits one bit period after a request before driving its reply.
// - register read is answered with the standard response frame.
// - response command while busy gets a diagnostic byte with busy in bit 0.
// - response commands arriving while a response is served are ignored.
// - every response starts with the diagnostic byte before any data.
// - communication error bits latch, hold, and clear after the next response.
// - response checksum covers the diagnostic byte and the data bytes.
// - diagnostic bits 7 and 6 are always sent as 0 and 1.
// - select 0, bit 1 flags sync bit rate out of range.
// - select 0, bit 2 flags mismatching consecutive sync bit widths.
// - select 0, bit 3 flags received checksum mismatch.
// - select 0, bit 4 flags invalid command code.
// - select 0, bit 5 flags general framing faults and contention.
// - select 1, bits 0-5 give busy, thr crc, freq, volt, 0, nvm crc.
// - controller supplies the serial clock; data moves on rxd and txd only.
// - outputs change on rising serial clock, inputs sampled on falling.
// - frames have no start, stop or wait bits and follow back to back.
// - no chip select; a three-bit address selects one of eight devices.
// - each frame is eight bits, least significant bit first.
// - io-pin transceiver is disabled when io-pin uart is selected and sync traffic runs.
// - sync mode is entered on the first rising serial clock edge, no enable.
// - non-register-read response requests carry no checksum; device makes its own.
// - a no-response command arriving while busy aborts earlier activity.
module usp_port (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // serial link
   input  wire logic        sclk_i,
   input  wire logic        rxd_i,
   output logic             txd_o,
   output logic             io_xcvr_en_o,
   // device core side
   input  wire logic        busy_i,
   input  wire logic        thr_crc_err_i,
   input  wire logic        freq_diag_err_i,
   input  wire logic        volt_diag_err_i,
   input  wire logic        nvm_crc_err_i,
   input  wire logic        contention_i,
   input  wire logic [5:0]  resp_len_i,
   input  wire logic [7:0]  resp_data_i,
   output logic      [5:0]  resp_idx_o,
   output logic             cmd_valid_o,
   output logic      [4:0]  cmd_code_o,
   output logic             abort_o,
   output logic      [7:0]  rx_data_o,
   output logic             rx_data_valid_o,
   output logic             resp_active_o
);
   import usp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // carry-wrapping byte sum; final checksum is its inverse
   function automatic logic [7:0] csum_add(input logic [7:0] acc, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, acc} + {1'b0, b};
      csum_add = s[7:0] + {7'h00, s[8]};
   endfunction

   // data bytes the controller sends after a command byte
   function automatic logic [5:0] cmd_nbytes(input logic [4:0] c);
      case (c)
         5'h00, 5'h01, 5'h02, 5'h03, 5'h04: cmd_nbytes = 6'h01;
         5'h11, 5'h12, 5'h13, 5'h14, 5'h15: cmd_nbytes = 6'h01;
         5'h09:                             cmd_nbytes = 6'h01;
         5'h0A, 5'h16:                      cmd_nbytes = 6'h02;
         5'h0C, 5'h17:                      cmd_nbytes = 6'h2B;
         5'h0E, 5'h18:                      cmd_nbytes = 6'h07;
         5'h10, 5'h19:                      cmd_nbytes = 6'h20;
         default:                           cmd_nbytes = 6'h00;
      endcase
   endfunction

   function automatic logic cmd_is_resp(input logic [4:0] c);
      case (c)
         5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0B, 5'h0D, 5'h0F: cmd_is_resp = 1'b1;
         default:                                                 cmd_is_resp = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
      abs_diff = (a > b) ? (a - b) : (b - a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // wishbone registers

   logic [4:0] ctrl_reg;
   logic [7:0] diag_cap_reg;
   logic [5:1] comm_err_reg;
   logic       sync_act_reg;
   usp_state_t state_reg;
   usp_state_t state_next;
   logic       wb_req;
   logic [31:0] rd_word;

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (wb_adr_i)
         `USP_OFS_CTRL:     rd_word[4:0] = ctrl_reg;
         `USP_OFS_STATUS:   rd_word[8:0] = {io_xcvr_en_o, resp_active_o, sync_act_reg, comm_err_reg, 1'b0};
         `USP_OFS_LASTDIAG: rd_word[7:0] = diag_cap_reg;
         default:           rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_word : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= `USP_CTRL_RST;
      end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `USP_OFS_CTRL) begin
         ctrl_reg <= wb_dat_i[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link input synchronisers and edge detect

   logic sclk_s1, sclk_s2, sclk_s3;
   logic rxd_s1, rxd_s2;
   logic sclk_rise, sclk_fall;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         rxd_s1  <= 1'b1;
         rxd_s2  <= 1'b1;
      end else begin
         sclk_s1 <= sclk_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         rxd_s1  <= rxd_i;
         rxd_s2  <= rxd_s1;
      end
   end

   assign sclk_rise = sclk_s2 & ~sclk_s3;
   assign sclk_fall = ~sclk_s2 & sclk_s3;

   // no enable bit: first clock edge switches the port over, and it stays
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_act_reg <= 1'b0;
      end else if (sclk_rise) begin
         sync_act_reg <= 1'b1;
      end
   end

   assign io_xcvr_en_o = ~(ctrl_reg[`USP_CTRL_IOSEL] & sync_act_reg);

   // a stalled clock realigns framing, since there is no start bit to find
   logic [8:0] idle_cnt_reg;
   logic       idle;

   always_ff @(posedge clk_i) begin
      if (rst_i || sclk_rise || sclk_fall) begin
         idle_cnt_reg <= 9'h000;
      end else if (!idle) begin
         idle_cnt_reg <= idle_cnt_reg + 9'h001;
      end
   end

   assign idle = (idle_cnt_reg == 9'(`USP_IDLE_CYC));

   ////////////////////////////////////////////////////////////////////////////
   // receive shifter: sample on falling edge, lsb first

   logic [7:0] rx_shift_reg;
   logic [2:0] rx_bit_reg;
   logic [7:0] rx_byte;
   logic       byte_done;
   logic       rx_phase;

   assign rx_phase  = (state_reg != ST_GAP) && (state_reg != ST_TX);
   assign rx_byte   = {rxd_s2, rx_shift_reg[7:1]};
   assign byte_done = sclk_fall && rx_phase && (rx_bit_reg == 3'h7);

   always_ff @(posedge clk_i) begin
      if (rst_i || idle || !rx_phase) begin
         rx_bit_reg   <= 3'h0;
         rx_shift_reg <= 8'h00;
      end else if (sclk_fall) begin
         rx_shift_reg <= rx_byte;
         rx_bit_reg   <= rx_bit_reg + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sync field bit width measurement

   logic [7:0] per_cnt_reg;
   logic [7:0] prev_w_reg;
   logic       e_rate, e_match;

   always_ff @(posedge clk_i) begin
      if (rst_i || sclk_fall) begin
         per_cnt_reg <= 8'h01;
      end else if (per_cnt_reg != 8'hFF) begin
         per_cnt_reg <= per_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_w_reg <= 8'h00;
      end else if (sclk_fall && state_reg == ST_SYNC) begin
         prev_w_reg <= per_cnt_reg;
      end
   end

   // first bit has no preceding falling edge to measure from
   always_comb begin
      e_rate  = 1'b0;
      e_match = 1'b0;
      if (sclk_fall && state_reg == ST_SYNC && rx_bit_reg != 3'h0) begin
         e_rate = (per_cnt_reg < 8'(`USP_MIN_BIT_CYC)) || (per_cnt_reg > 8'(`USP_MAX_BIT_CYC));
         if (rx_bit_reg > 3'h1) begin
            e_match = abs_diff(per_cnt_reg, prev_w_reg) > 8'(`USP_WIDTH_TOL);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer

   logic [4:0] cmd_reg;
   logic       addr_ok_reg;
   logic [5:0] remain_reg;
   logic [7:0] rx_csum_reg;
   logic [5:0] resp_len_reg;
   logic [5:0] tx_idx_reg;
   logic [2:0] tx_bit_reg;
   logic [7:0] tx_byte_reg;
   logic [7:0] tx_csum_reg;
   logic       txd_reg;
   logic       e_csum, e_cmd, e_frame;
   logic       resp_start, resp_done;
   logic       addr_hit;
   logic [7:0] diag_w;
   logic [7:0] tx_mux;

   assign addr_hit = (rx_byte[7:5] == ctrl_reg[`USP_CTRL_ADDR_LO +: 3])
                     || (rx_byte[4:0] >= `USP_CMD_BCAST_LO);

   always_comb begin
      state_next = state_reg;
      e_csum     = 1'b0;
      e_cmd      = 1'b0;
      e_frame    = 1'b0;
      resp_start = 1'b0;
      resp_done  = 1'b0;
      if (idle && rx_phase) begin
         state_next = ST_SYNC;
      end else begin
         unique case (state_reg)
            ST_SYNC: begin
               if (byte_done) begin
                  e_frame    = (rx_byte != `USP_SYNC_BYTE);
                  state_next = ST_CMD;
               end
            end
            ST_CMD: begin
               if (byte_done) begin
                  if (rx_byte[4:0] > `USP_CMD_LAST) begin
                     e_cmd      = 1'b1;
                     state_next = ST_IGN;
                  end else if (cmd_is_resp(rx_byte[4:0]) && rx_byte[4:0] != `USP_CMD_REGREAD) begin
                     resp_start = addr_hit;
                     state_next = addr_hit ? ST_GAP : ST_IGN;
                  end else if (cmd_nbytes(rx_byte[4:0]) == 6'h00) begin
                     state_next = ST_CSUM;
                  end else begin
                     state_next = ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (byte_done && remain_reg == 6'h01) begin
                  state_next = ST_CSUM;
               end
            end
            ST_CSUM: begin
               if (byte_done) begin
                  if (rx_byte != ~rx_csum_reg) begin
                     e_csum     = 1'b1;
                     state_next = ST_SYNC;
                  end else if (cmd_reg == `USP_CMD_REGREAD && addr_ok_reg) begin
                     resp_start = 1'b1;
                     state_next = ST_GAP;
                  end else begin
                     state_next = ST_SYNC;
                  end
               end
            end
            ST_GAP: begin
               if (sclk_rise) begin
                  state_next = ST_TX;
               end
            end
            ST_TX: begin
               if (sclk_rise && tx_bit_reg == 3'h0 && tx_idx_reg == resp_len_reg + 6'h02) begin
                  resp_done  = 1'b1;
                  state_next = ST_SYNC;
               end else if (idle) begin
                  resp_done  = 1'b1;
                  state_next = ST_SYNC;
               end
            end
            ST_IGN: begin
               state_next = ST_IGN;
            end
            default: begin
               state_next = ST_SYNC;
            end
         endcase
      end
   end

   // new requests are not decoded until the running response has ended
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_SYNC;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_reg     <= 5'h00;
         addr_ok_reg <= 1'b0;
         remain_reg  <= 6'h00;
         rx_csum_reg <= 8'h00;
      end else if (byte_done && state_reg == ST_CMD) begin
         cmd_reg     <= rx_byte[4:0];
         addr_ok_reg <= addr_hit;
         remain_reg  <= cmd_nbytes(rx_byte[4:0]);
         rx_csum_reg <= csum_add(8'h00, rx_byte);
      end else if (byte_done && state_reg == ST_DATA) begin
         remain_reg  <= remain_reg - 6'h01;
         rx_csum_reg <= csum_add(rx_csum_reg, rx_byte);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core strobes

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_valid_o     <= 1'b0;
         cmd_code_o      <= 5'h00;
         abort_o         <= 1'b0;
         rx_data_o       <= 8'h00;
         rx_data_valid_o <= 1'b0;
      end else begin
         cmd_valid_o     <= 1'b0;
         abort_o         <= 1'b0;
         rx_data_valid_o <= 1'b0;
         if (byte_done && state_reg == ST_DATA && addr_ok_reg) begin
            rx_data_o       <= rx_byte;
            rx_data_valid_o <= 1'b1;
         end
         if (resp_start && !busy_i) begin
            cmd_valid_o <= 1'b1;
            cmd_code_o  <= (state_reg == ST_CMD) ? rx_byte[4:0] : cmd_reg;
         end
         if (state_reg == ST_CSUM && state_next == ST_SYNC && byte_done && !e_csum && addr_ok_reg) begin
            cmd_valid_o <= 1'b1;
            cmd_code_o  <= cmd_reg;
            abort_o     <= busy_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // diagnostic byte and error latches

   always_comb begin
      if (ctrl_reg[`USP_CTRL_DIAGSEL]) begin
         diag_w = {`USP_DIAG_TOP, nvm_crc_err_i, 1'b0, volt_diag_err_i, freq_diag_err_i,
                   thr_crc_err_i, busy_i};
      end else begin
         diag_w = {`USP_DIAG_TOP, comm_err_reg, busy_i};
      end
   end

   // set wins over the clear at the end of a response
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comm_err_reg <= 5'h00;
      end else begin
         comm_err_reg <= (resp_done ? 5'h00 : comm_err_reg)
                         | {e_frame | (contention_i & ~state_reg[5]) | (contention_i & txd_reg & ~rxd_s2 & state_reg[5]),
                            e_cmd, e_csum, e_match, e_rate};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         diag_cap_reg <= 8'h00;
         resp_len_reg <= 6'h00;
      end else if (resp_start) begin
         diag_cap_reg <= diag_w;
         resp_len_reg <= busy_i ? 6'h00 : resp_len_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit shifter: drive on rising edge

   assign resp_idx_o = tx_idx_reg - 6'h01;

   always_comb begin
      if (tx_idx_reg == 6'h00) begin
         tx_mux = diag_cap_reg;
      end else if (tx_idx_reg <= resp_len_reg) begin
         tx_mux = resp_data_i;
      end else begin
         tx_mux = ~tx_csum_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg != ST_TX) begin
         tx_idx_reg  <= 6'h00;
         tx_bit_reg  <= 3'h0;
         tx_byte_reg <= 8'h00;
         tx_csum_reg <= 8'h00;
      end else if (sclk_rise && !resp_done) begin
         tx_bit_reg <= tx_bit_reg + 3'h1;
         if (tx_bit_reg == 3'h0) begin
            tx_byte_reg <= tx_mux;
            tx_csum_reg <= csum_add(tx_csum_reg, tx_mux);
         end
         if (tx_bit_reg == 3'h7) begin
            tx_idx_reg <= tx_idx_reg + 6'h01;
         end
      end
   end

   // line rests high outside a response
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txd_reg <= 1'b1;
      end else if (state_reg != ST_TX || resp_done) begin
         txd_reg <= 1'b1;
      end else if (sclk_rise) begin
         txd_reg <= (tx_bit_reg == 3'h0) ? tx_mux[0] : tx_byte_reg[tx_bit_reg];
      end
   end

   assign txd_o         = txd_reg;
   assign resp_active_o = state_reg[4] | state_reg[5];

endmodule

// *** test/usp_port_props.sv ***
// concurrent checks on the serial response port
`timescale 1ns/1ns
module usp_port_props (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        sclk_i,
   input wire logic        txd_o,
   input wire logic        io_xcvr_en_o,
   input wire logic        busy_i,
   input wire logic        cmd_valid_o,
   input wire logic        abort_o,
   input wire logic        rx_data_valid_o,
   input wire logic        resp_active_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_wb_ack_pulse: assert property (wb_req |=> ack_pulse) else $error("ack missing or longer than one cycle");
   a_wb_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   a_reset_out_idle: assert property (disable iff (1'b0) rst_i |=> txd_o && io_xcvr_en_o && !resp_active_o)
      else $error("outputs not idle after reset");
   a_txd_idle_high: assert property ((!resp_active_o && !$past(resp_active_o)) |-> txd_o)
      else $error("txd low outside a response");
   // txd is re-timed a few clocks after the synchronised rising sclk edge
   a_tx_after_rise: assert property ($changed(txd_o) |-> ($past(sclk_i, 1) || $past(sclk_i, 2) || $past(sclk_i, 3)
      || $past(sclk_i, 4) || $past(sclk_i, 5))) else $error("txd changed away from a rising sclk");
   a_abort_with_cmd: assert property (abort_o |-> cmd_valid_o) else $error("abort without command");
   a_abort_if_busy: assert property (abort_o |-> $past(busy_i)) else $error("abort while idle");
   a_cmd_one_pulse: assert property (cmd_valid_o |=> !cmd_valid_o) else $error("command pulse too long");
   a_resp_no_rx: assert property (resp_active_o |-> !rx_data_valid_o)
      else $error("data decoded during a response");
endmodule
bind usp_port usp_port_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sclk_i(sclk_i), .txd_o(txd_o), .io_xcvr_en_o(io_xcvr_en_o),
   .busy_i(busy_i), .cmd_valid_o(cmd_valid_o), .abort_o(abort_o), .rx_data_valid_o(rx_data_valid_o),
   .resp_active_o(resp_active_o));

// *** test/usp_ctrl_model.sv ***
// controller-side model of the clocked serial link
`timescale 1ns/1ns
module usp_ctrl_model (
   output logic      sclk_o,
   output logic      rxd_o,
   input  wire logic txd_i
);
   logic q;
   // half period of the link clock, widened by the bench to provoke rate errors
   int   half = 80;
   initial begin
      sclk_o = 1'b0;
      rxd_o = 1'b1;
   end
   task automatic bit_cycle(input logic d);
      sclk_o = 1'b1;
      rxd_o = d;
      #half;
      q = txd_i;
      sclk_o = 1'b0;
      #half;
   endtask
   task automatic xfer(input logic [31:0] req, input int nreq, input int nresp, output logic [31:0] resp);
      resp = 32'h0;
      #7;
      // whole bytes, lsb first, no framing bits
      for (int i = 0; i < 8 * nreq; i++) bit_cycle(req[i]);
      if (nresp > 0) begin
         bit_cycle(1'b1);
         for (int i = 0; i < 8 * nresp; i++) begin
            bit_cycle(1'b1);
            resp[i] = q;
         end
         bit_cycle(1'b1);
      end
      // clock stands still long enough to realign framing
      #6000;
   endtask
endmodule

// *** test/usp_port_tb.sv ***
// self-checking bench of the serial response port
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module usp_port_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack, sclk, rxd, txd, xcvr, cmd_valid, abort, rx_valid, resp_act;
   logic        busy = 1'b0;
   logic        thr = 1'b0;
   logic        freq = 1'b0;
   logic        volt = 1'b0;
   logic        nvm = 1'b0;
   logic        cont = 1'b0;
   logic [5:0]  resp_len = 6'h00;
   logic [5:0]  resp_idx;
   logic [7:0]  resp_data = 8'h00;
   logic [4:0]  cmd_code, last_code;
   logic [7:0]  rx_data, last_rx;
   logic        saw_abort = 1'b0;
   logic [31:0] rd, resp, req;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          cmd_cnt = 0;
   int          n;
   always #10 clk_i = ~clk_i;
   usp_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sclk_i(sclk), .rxd_i(rxd),
      .txd_o(txd), .io_xcvr_en_o(xcvr), .busy_i(busy), .thr_crc_err_i(thr), .freq_diag_err_i(freq),
      .volt_diag_err_i(volt), .nvm_crc_err_i(nvm), .contention_i(cont), .resp_len_i(resp_len),
      .resp_data_i(resp_data), .resp_idx_o(resp_idx), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .abort_o(abort), .rx_data_o(rx_data), .rx_data_valid_o(rx_valid), .resp_active_o(resp_act));
   usp_ctrl_model m (.sclk_o(sclk), .rxd_o(rxd), .txd_i(txd));
   always @(posedge clk_i) begin
      resp_data <= 8'hA0 + {2'b00, resp_idx};
      if (cmd_valid === 1'b1) begin
         cmd_cnt++;
         last_code = cmd_code;
      end
      if (abort === 1'b1) saw_abort = 1'b1;
      if (rx_valid === 1'b1) last_rx = rx_data;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 100);
      q = rdat;
      if (k >= 100) num_errors++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // inverted one's complement sum with end-around carry
   function automatic logic [7:0] cks(input logic [31:0] b, input int nb);
      logic [8:0] s;
      s = 9'h0;
      for (int i = 0; i < nb; i++) begin
         s = {1'b0, s[7:0]} + {1'b0, b[8*i+:8]};
         s = {1'b0, s[7:0]} + {8'h00, s[8]};
      end
      return ~s[7:0];
   endfunction
   task automatic chk_resp(input logic [31:0] got, input logic [7:0] diag, input int nd);
      logic [31:0] e;
      e = {24'h0, diag};
      for (int i = 0; i < nd; i++) e[8*(i+1)+:8] = 8'hA0 + 8'(i);
      e[8*(nd+1)+:8] = cks(e, nd + 1);
      `CHK("response", e, got)
   endtask
   task automatic cmd_resp(input logic [7:0] cmd, input logic [7:0] diag, input int nd);
      m.xfer({16'h0, cmd, 8'h55}, 2, nd + 2, resp);
      chk_resp(resp, diag, nd);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      num_errors++;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb_xfer(1'b0, 8'h00, 32'h0, rd);
      `CHK("ctrl", 32'h0, rd)
      wb_xfer(1'b0, 8'h04, 32'h0, rd);
      `CHK("status", 32'h100, rd)
      wb_xfer(1'b0, 8'h0C, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      // address 3, io-pin uart selected, comm error meaning
      wb_xfer(1'b1, 8'h00, 32'h16, rd);
      wb_xfer(1'b0, 8'h00, 32'h0, rd);
      `CHK("ctrl", 32'h16, rd)
      req = {8'h00, 8'hAA, 8'h69, 8'h55};
      req[31:24] = cks(req >> 8, 2);
      resp_len <= 6'd1;
      m.xfer(req, 4, 3, resp);
      chk_resp(resp, 8'h40, 1);
      `CHK("code", 5'h09, last_code)
      `CHK("xcvr", 1'b0, xcvr)
      wb_xfer(1'b0, 8'h08, 32'h0, rd);
      `CHK("lastdiag", 32'h40, rd)
      m.xfer(req ^ 32'h0100_0000, 4, 0, resp);
      @(posedge clk_i);
      resp_len <= 6'd2;
      cmd_resp(8'h65, 8'h48, 2);
      cmd_resp(8'h65, 8'h40, 2);
      m.xfer(32'h7B55, 2, 0, resp);
      cmd_resp(8'h65, 8'h50, 2);
      // slow clock (110 clocks a bit) and a corrupted sync byte
      m.half = 1100;
      m.xfer(32'h0054, 2, 0, resp);
      m.half = 80;
      cmd_resp(8'h65, 8'h62, 2);
      @(posedge clk_i);
      cont <= 1'b1;
      @(posedge clk_i);
      cont <= 1'b0;
      cmd_resp(8'h65, 8'h60, 2);
      n = cmd_cnt;
      m.xfer(32'h4555, 2, 0, resp);
      `CHK("foreign address", n, cmd_cnt)
      wb_xfer(1'b1, 8'h00, 32'h17, rd);
      busy <= 1'b1;
      n = cmd_cnt;
      for (int p = 0; p < 2; p++) begin
         @(posedge clk_i);
         thr <= (p == 0);
         volt <= (p == 0);
         freq <= (p == 1);
         nvm <= (p == 1);
         cmd_resp(8'h65, (p == 1) ? 8'h65 : 8'h4B, 0);
      end
      `CHK("busy commands", n, cmd_cnt)
      req = {8'h00, 8'h07, 8'h11, 8'h55};
      req[31:24] = cks(req >> 8, 2);
      m.xfer(req, 4, 0, resp);
      `CHK("abort", 1'b1, saw_abort)
      `CHK("rx byte", 8'h07, last_rx)
      final_report;
   end
endmodule
